// *** hdl/jtf_framer.sv ***
// one channel: sample coding, frame mapping, link sequence and 8b/10b on one or two lanes
// What this block does
// - samples leave in two's complement unless offset binary is selected
// - coding choice is a control input, applied before framing and encoding
// - the channel uses one or two lanes, selected by control
// - a lane never carries data of another channel
// - one lane: ten bits per octet, two octets per sample
// - two lanes: each lane carries one octet per sample
// - octets, samples per frame and density follow the lane count only
// - resolution, sample bits, control bits, words and converter count are fixed
// - the channel is its own link with one converter
// - one lane: frame is upper octet then lower octet, msb first
// - framing followed by 8b/10b encoding on each lane
// - subclass 1: sysref edge aligns frame and multiframe counters
// - test sequences D21.5, K28.5, repeated alignment, PRBS7, PRBS23, ramp
// - no idle link mode, no short or long transport test patterns
// - no transmit lane polarity inversion
// - two lanes: one octet per frame, high density; one lane: two, not
// - frames per multiframe 9 to 32 one lane, 17 to 32 two lanes
// - scrambling off unless enabled; alignment sequence is never scrambled
`timescale 1ns/10ps
module jtf_framer #(
  parameter int SAMPLE_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [SAMPLE_W-1:0] i_sample,
  input wire jtf_pkg::jtf_cfg_s i_cfg,
  input wire logic i_sysref,
  input wire logic i_sync_n,
  output logic [9:0] o_lane0,
  output logic [9:0] o_lane1,
  output logic o_sample_take,
  output logic o_link_data,
  output logic [1:0] o_octets_per_frame,
  output logic o_hd
);
  import jtf_pkg::*;

  // datapath slices are hard-wired for the fixed resolution
  if (SAMPLE_W != LINK_NP || LINK_N != LINK_NP || LINK_M != 1 || LINK_CS != 0 || LINK_CF != 0) begin : g_chk
    $error("jtf_framer serves 16-bit samples only");
  end

  localparam jtf_state_s ST_RST = '{st: LK_CGS, scr: {SCR_SEED, SCR_SEED}, prbs: {PRBS_SEED, PRBS_SEED},
    f: F_1L, take: 1'b1, default: '0};

  jtf_state_s q;
  jtf_state_s n;
  logic dual;
  logic frame_end;
  logic mf_end;
  logic mf_start;
  logic sr_edge;
  logic take;
  logic prbs_on;
  logic [4:0] kmin;
  logic [4:0] km1;
  logic [15:0] smp;
  logic [7:0] idx8;
  logic [7:0] oct_v [2];
  logic [7:0] d_v;
  logic k_v;
  logic [10:0] e_v;
  logic [22:0] s_v;
  logic [32:0] p_v;

  always_comb begin
    n = q;
    dual = i_cfg.dual;
    // below-range settings clamp to the least legal multiframe
    kmin = dual ? KM1_MIN_2L : KM1_MIN_1L;
    km1 = (i_cfg.km1 < kmin) ? kmin : i_cfg.km1;
    frame_end = dual || q.oct;
    mf_end = frame_end && (q.fr == km1);
    mf_start = !q.oct && (q.fr == 5'h00);
    // plain edge detect, so any sysref shape realigns the same way
    sr_edge = i_sysref && !q.sref;
    n.sref = i_sysref;
    if (sr_edge) begin
      n.oct = 1'b0;
      n.fr = 5'h00;
    end else begin
      n.oct = dual ? 1'b0 : ~q.oct;
      if (frame_end) begin
        n.fr = mf_end ? 5'h00 : q.fr + 5'h01;
      end
    end
    n.take = !n.oct;
    take = !q.oct;
    smp = (i_cfg.test == TM_RAMP) ? q.ramp : i_sample;
    smp[15] = smp[15] ^ i_cfg.offset_bin;
    if (take) begin
      n.samp = smp;
      n.ramp = q.ramp + i_cfg.ramp_step;
    end
    oct_v[0] = q.oct ? q.samp[7:0] : smp[15:8];
    oct_v[1] = smp[7:0];
    idx8 = dual ? {3'h0, q.fr} : {2'h0, q.fr, q.oct};
    case (q.st)
      LK_CGS: begin
        // leave at a multiframe end so alignment opens on a multiframe start
        if (i_sync_n && mf_end) begin
          n.st = LK_ILA;
          n.ila = 2'h0;
        end
      end
      LK_ILA: begin
        if (mf_end) begin
          n.ila = q.ila + 2'h1;
          if (q.ila == ILA_LAST_MF && i_cfg.test != TM_ILA) begin
            n.st = LK_DATA;
          end
        end
      end
      LK_DATA: begin
      end
      default: begin
        n.st = LK_CGS;
      end
    endcase
    if (!i_sync_n) begin
      n.st = LK_CGS;
    end
    n.dat = (n.st == LK_DATA);
    n.hd = dual;
    n.f = dual ? F_2L : F_1L;
    prbs_on = (i_cfg.test == TM_PRBS7) || (i_cfg.test == TM_PRBS23);
    d_v = 8'h00;
    k_v = 1'b0;
    e_v = 11'h000;
    s_v = 23'h000000;
    p_v = 33'h000000000;
    for (int l = 0; l < 2; l++) begin
      k_v = 1'b0;
      // spare test code sends plain data; no idle or transport pattern path
      d_v = oct_v[l];
      if (i_cfg.test == TM_K285 || q.st == LK_CGS) begin
        k_v = 1'b1;
        d_v = K28_5;
      end else if (q.st == LK_ILA) begin
        // alignment octets bypass the scrambler entirely
        k_v = mf_start || mf_end;
        d_v = mf_start ? K28_0 : (mf_end ? K28_3 : idx8);
      end else if (i_cfg.test == TM_D215) begin
        d_v = D21_5;
      end else if (i_cfg.scr_en) begin
        s_v = scramble(d_v, q.scr[l]);
        d_v = s_v[7:0];
        n.scr[l] = s_v[22:8];
      end
      e_v = enc8b10b(d_v, k_v, q.rd[l]);
      p_v = prbs10(q.prbs[l], i_cfg.test == TM_PRBS23);
      if (prbs_on) begin
        n.lane[l] = p_v[9:0];
        n.prbs[l] = p_v[32:10];
      end else begin
        n.lane[l] = e_v[9:0];
        n.rd[l] = e_v[10];
      end
    end
    // lane 1 stays quiet in single-lane use, it never borrows other data
    if (!dual) begin
      n.lane[1] = LANE_OFF;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // polarity is sent as encoded; no inversion path exists
  assign o_lane0 = q.lane[0];
  assign o_lane1 = q.lane[1];
  assign o_sample_take = q.take;
  assign o_link_data = q.dat;
  assign o_octets_per_frame = q.f;
  assign o_hd = q.hd;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  property p_coding;
    (take && i_cfg.test != TM_RAMP) |=> (q.samp == {$past(i_sample[15] ^ i_cfg.offset_bin), $past(i_sample[14:0])});
  endproperty
  a_coding: assert property (p_coding) else $error("sample coding wrong");
  property p_lane1_off;
    !dual |=> (o_lane1 == LANE_OFF);
  endproperty
  a_lane1_off: assert property (p_lane1_off) else $error("lane 1 active in single lane");
  property p_single_rate;
    (!dual && !sr_edge && o_sample_take) ##1 (!dual && !sr_edge) |-> !o_sample_take ##1 o_sample_take;
  endproperty
  a_single_rate: assert property (p_single_rate) else $error("single lane take spacing wrong");
  property p_dual_rate;
    dual |=> o_sample_take;
  endproperty
  a_dual_rate: assert property (p_dual_rate) else $error("dual lane take missing");
  property p_frame_cfg;
    ##1 (o_hd == $past(dual)) && (o_octets_per_frame == ($past(dual) ? F_2L : F_1L));
  endproperty
  a_frame_cfg: assert property (p_frame_cfg) else $error("frame settings wrong");
  property p_mf_wrap;
    (mf_end && !sr_edge) |=> (q.fr == 5'h00);
  endproperty
  a_mf_wrap: assert property (p_mf_wrap) else $error("multiframe did not wrap");
  property p_kmin;
    km1 >= (dual ? KM1_MIN_2L : KM1_MIN_1L);
  endproperty
  a_kmin: assert property (p_kmin) else $error("multiframe length below range");
  property p_ila_plain;
    (q.st == LK_ILA) |=> $stable(q.scr);
  endproperty
  a_ila_plain: assert property (p_ila_plain) else $error("scrambler moved during alignment");
  property p_k285;
    (i_cfg.test == TM_K285) |=> (o_lane0 == K285_RDN || o_lane0 == K285_RDP);
  endproperty
  a_k285: assert property (p_k285) else $error("K28.5 test not sent");
  property p_sysref;
    sr_edge |=> (q.oct == 1'b0) && (q.fr == 5'h00);
  endproperty
  a_sysref: assert property (p_sysref) else $error("sysref did not align counters");
  property p_ila_start;
    ((q.st == LK_ILA) && ($past(q.st) != LK_ILA)) |-> mf_start;
  endproperty
  a_ila_start: assert property (p_ila_start) else $error("alignment did not open a multiframe");

  c_ila_to_data: cover property ((q.st == LK_ILA) ##1 (q.st == LK_DATA));
  c_sysref: cover property (sr_edge ##1 (q.st == LK_DATA));
  c_dual_data: cover property (dual && o_link_data);
  c_prbs: cover property (prbs_on [*4]);
endmodule : jtf_framer

// *** hdl/jtf_pkg.sv ***
// shared constants, types and coding functions of the lane framer
package jtf_pkg;
  localparam logic [7:0] K28_0 = 8'h1C;
  localparam logic [7:0] K28_3 = 8'h7C;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [7:0] D21_5 = 8'hB5;
  localparam logic [9:0] K285_RDN = 10'h0FA;
  localparam logic [9:0] K285_RDP = 10'h305;
  localparam logic [9:0] LANE_OFF = 10'h000;
  localparam logic [4:0] KM1_MIN_1L = 5'h08;
  localparam logic [4:0] KM1_MIN_2L = 5'h10;
  localparam logic [1:0] F_1L = 2'h2;
  localparam logic [1:0] F_2L = 2'h1;
  localparam logic [1:0] ILA_LAST_MF = 2'h3;
  // fixed link parameters, no control reaches them
  localparam int LINK_N = 16;
  localparam int LINK_NP = 16;
  localparam int LINK_CS = 0;
  localparam int LINK_CF = 0;
  localparam int LINK_M = 1;
  localparam logic [2:0] TM_NONE = 3'h0;
  localparam logic [2:0] TM_D215 = 3'h1;
  localparam logic [2:0] TM_K285 = 3'h2;
  localparam logic [2:0] TM_ILA = 3'h3;
  localparam logic [2:0] TM_PRBS7 = 3'h4;
  localparam logic [2:0] TM_PRBS23 = 3'h5;
  localparam logic [2:0] TM_RAMP = 3'h6;
  localparam logic [5:0] K28_6B = 6'h0F;
  localparam logic [5:0] D7_6B = 6'h38;
  localparam logic [3:0] ALT7_4B = 4'h7;
  localparam logic [3:0] D3_4B = 4'hC;
  localparam logic [14:0] SCR_SEED = 15'h7FFF;
  localparam logic [22:0] PRBS_SEED = 23'h7FFFFF;
  localparam logic [5:0] T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13, 6'h32,
    6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  typedef enum logic [1:0] {LK_CGS, LK_ILA, LK_DATA} jtf_link_e;

  typedef struct packed {
    logic offset_bin;
    logic dual;
    logic scr_en;
    logic [2:0] test;
    logic [4:0] km1;
    logic [15:0] ramp_step;
  } jtf_cfg_s;

  typedef struct packed {
    jtf_link_e st;
    logic oct;
    logic [4:0] fr;
    logic [1:0] ila;
    logic sref;
    logic [15:0] ramp;
    logic [15:0] samp;
    logic [1:0] rd;
    logic [1:0][14:0] scr;
    logic [1:0][22:0] prbs;
    logic [1:0][9:0] lane;
    logic take;
    logic dat;
    logic hd;
    logic [1:0] f;
  } jtf_state_s;

  // returns {running disparity after, abcdei fghj}; a is bit 9 and leaves first
  function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic r;
    logic alt;
    c6 = k ? K28_6B : T6[d[4:0]];
    if (rd && (($countones(c6) != 3) || (c6 == D7_6B))) c6 = ~c6;
    r = rd ^ ($countones(c6) != 3);
    alt = (d[7:5] == 3'h7) && (k || (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
      (r && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
    c4 = alt ? ALT7_4B : T4[d[7:5]];
    if (r && (($countones(c4) != 2) || (c4 == D3_4B))) c4 = ~c4;
    if (k && rd && ($countones(c4) == 2) && (c4 != D3_4B)) c4 = ~c4;
    return {r ^ ($countones(c4) != 2), c6, c4};
  endfunction : enc8b10b

  // self-synchronous 1 + x^14 + x^15, msb first; returns {state, octet}
  function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] s);
    logic [7:0] o;
    logic b;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ s[14] ^ s[13];
      o[i] = b;
      s = {s[13:0], b};
    end
    return {s, o};
  endfunction : scramble

  // ten prbs bits per octet slot; returns {state, bits}
  function automatic logic [32:0] prbs10(input logic [22:0] s, input logic p23);
    logic [9:0] o;
    logic b;
    o = 10'h000;
    for (int i = 9; i >= 0; i--) begin
      b = p23 ? (s[22] ^ s[17]) : (s[6] ^ s[5]);
      o[i] = b;
      s = {s[21:0], b};
    end
    return {s, o};
  endfunction : prbs10
endpackage : jtf_pkg

// *** tb/jtf_rx_model.sv ***
// receiver-side model: asks for sync until it sees a steady comma stream
`timescale 1ns/10ps
module jtf_rx_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_relink,
  input wire logic [9:0] i_lane0,
  output logic o_sync_n
);
  import jtf_pkg::*;
  logic [2:0] commas_q;
  // either disparity counts as a comma, the line has no polarity swap
  always @(posedge i_mclk) begin
    if (i_rst || i_relink) begin
      commas_q <= 3'h0;
      o_sync_n <= 1'b0;
    end else if (!o_sync_n) begin
      if (i_lane0 == K285_RDN || i_lane0 == K285_RDP) begin
        commas_q <= commas_q + 3'h1;
        if (commas_q == 3'h4) o_sync_n <= 1'b1;
      end else begin
        commas_q <= 3'h0;
      end
    end
  end
endmodule : jtf_rx_model

// *** tb/jtf_framer_test.sv ***
// self-checking bench of the lane framer
`timescale 1ns/10ps
module jtf_framer_test;
  import jtf_pkg::*;
  `define CHK(a, b) begin if ((a) !== (b)) begin n_mismatch++; $display("Error t=%0t got %h exp %h", $time, a, b); end checked++; end
  logic mclk, rst = 1'b1, sysref = 1'b0, relink = 1'b1, sync_n, take, link_data, hd, chk_en = 1'b0;
  logic [15:0] sample = 16'h0000, pick = 16'hB54A, nxt, ramp_q = 16'h0000, v;
  logic [15:0] pool [4] = '{16'hB54A, 16'h4AB5, 16'hB5B5, 16'h4A4A};
  jtf_cfg_s cfg = '0;
  logic [9:0] lane0, lane1, exp0, exp1, pend;
  logic [1:0] opf;
  int n_mismatch = 0, checked = 0, seed = 32'h9198D060;
  jtf_framer dut (.i_mclk(mclk), .i_rst(rst), .i_sample(sample), .i_cfg(cfg), .i_sysref(sysref), .i_sync_n(sync_n),
    .o_lane0(lane0), .o_lane1(lane1), .o_sample_take(take), .o_link_data(link_data), .o_octets_per_frame(opf),
    .o_hd(hd));
  jtf_rx_model rx (.i_mclk(mclk), .i_rst(rst), .i_relink(relink), .i_lane0(lane0), .o_sync_n(sync_n));
  // balanced octets need no disparity tracking; 3FF marks an octet left unpredicted
  function automatic logic [9:0] code(input logic [7:0] o);
    return (o == 8'hB5) ? 10'h2AA : ((o == 8'h4A) ? 10'h155 : 10'h3FF);
  endfunction : code
  function automatic logic is_k0(input logic [9:0] c);
    return c == 10'h0F4 || c == 10'h30B;
  endfunction : is_k0
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (chk_en) begin
      if (exp0 !== 10'h3FF) `CHK(lane0, exp0)
      if (exp1 !== 10'h3FF) `CHK(lane1, exp1)
    end
    if (rst) begin
      ramp_q <= 16'h0000;
    end else if (take) begin
      ramp_q <= ramp_q + cfg.ramp_step;
    end
    v = (cfg.test == TM_RAMP) ? (ramp_q ^ {cfg.offset_bin, 15'h0000}) : pick;
    if (take) begin
      exp0 <= code(v[15:8]);
      exp1 <= cfg.dual ? code(v[7:0]) : LANE_OFF;
      pend <= code(v[7:0]);
    end else begin
      exp0 <= pend;
      exp1 <= LANE_OFF;
    end
    nxt = pool[$unsigned($random(seed)) % 4];
    pick <= nxt;
    sample <= nxt ^ {cfg.offset_bin, 15'h0000};
  end
  task automatic relink_to(input logic dual, input logic [2:0] tm, input logic [4:0] km1, input logic scr);
    chk_en <= 1'b0;
    relink <= 1'b1;
    cfg <= '{offset_bin: 1'($random(seed)), dual: dual, scr_en: scr, test: tm, km1: km1, ramp_step: 16'h0101};
    repeat (4) @(posedge mclk);
    relink <= 1'b0;
  endtask : relink_to
  task automatic wait_data();
    int n = 0;
    while (link_data !== 1'b1 && n < 600) begin
      @(posedge mclk);
      n++;
    end
    `CHK(link_data, 1'b1)
    repeat (4) @(posedge mclk);
  endtask : wait_data
  // cycles from one multiframe start marker to the next
  task automatic mf_len(input int exp);
    int n = 0;
    int t = 0;
    while (!is_k0(lane0) && n < 600) begin
      @(posedge mclk);
      n++;
    end
    do begin
      @(posedge mclk);
      t++;
    end while (!is_k0(lane0) && t < 600);
    `CHK(t, exp)
  endtask : mf_len
  // each new bit must follow from two earlier ones of the same stream
  task automatic prbs_chk(input int a, input int b);
    logic [39:0] h = '0;
    logic [9:0] e;
    for (int c = 0; c < 20; c++) begin
      @(posedge mclk);
      h = {h[29:0], lane0};
      for (int i = 0; i < 10; i++) e[i] = h[i+a] ^ h[i+b];
      if (c > 3) `CHK(h[9:0], e)
    end
  endtask : prbs_chk
  task automatic sysref_chk();
    int t = 0;
    sysref <= 1'b1;
    @(posedge mclk);
    sysref <= 1'b0;
    while (!is_k0(lane0) && t < 4) begin
      @(posedge mclk);
      t++;
    end
    `CHK(is_k0(lane0), 1'b1)
    repeat (25) @(posedge mclk);
  endtask : sysref_chk
  task automatic results();
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    #(4 * 60000);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(lane0 == K285_RDN || lane0 == K285_RDP, 1'b1)
    `CHK(opf, F_1L)
    for (int d = 0; d < 2; d++) begin
      relink_to(d[0], TM_NONE, 5'h00, 1'b0);
      mf_len(d ? 17 : 18);
      wait_data();
      `CHK(opf, d ? F_2L : F_1L)
      `CHK(hd, d[0])
      chk_en <= 1'b1;
      repeat (200) @(posedge mclk);
      relink_to(d[0], TM_NONE, 5'h14, 1'b1);
      mf_len(d ? 21 : 42);
      relink_to(d[0], TM_D215, 5'h00, 1'b0);
      wait_data();
      `CHK(lane0, 10'h2AA)
      relink_to(d[0], TM_K285, 5'h00, 1'b0);
      repeat (8) @(posedge mclk);
      `CHK(lane0 == K285_RDN || lane0 == K285_RDP, 1'b1)
      relink_to(d[0], TM_ILA, 5'h00, 1'b0);
      mf_len(d ? 17 : 18);
      for (int p = 0; p < 3; p++) sysref_chk();
      relink_to(d[0], TM_PRBS7, 5'h00, 1'b0);
      prbs_chk(7, 6);
      relink_to(d[0], TM_PRBS23, 5'h00, 1'b0);
      prbs_chk(23, 18);
      relink_to(d[0], TM_RAMP, 5'h00, 1'b0);
      wait_data();
      chk_en <= 1'b1;
      repeat (600) @(posedge mclk);
    end
    results();
  end
endmodule : jtf_framer_test
